// file: core/wsc_pkg.sv
// package: register map, field layout, reset values and states of the watchdog and sleep control
package wsc_pkg;

   // register byte addresses on the apb bus
   localparam logic [11:0] WSC_ADDR_SOFT_CONTROL = 12'h000;
   localparam logic [11:0] WSC_ADDR_CAUSE_STATUS = 12'h004;
   localparam logic [11:0] WSC_ADDR_CONFIG_HIGH = 12'h008;

   // watchdog_soft_control layout
   localparam int WSC_SOFT_ON_BIT = 0;
   localparam logic WSC_SOFT_ON_RST = 1'b0;

   // watchdog_config_high layout
   localparam int WSC_FUSE_ON_BIT = 0;
   localparam int WSC_SCALE_LSB = 1;
   localparam int WSC_SCALE_MSB = 3;
   localparam int WSC_SCALE_W = 3;

   // reset_cause_status layout
   localparam int WSC_TIMEOUT_BIT = 3;
   localparam int WSC_POWERDOWN_BIT = 2;
   localparam logic WSC_TIMEOUT_RST = 1'b1;
   localparam logic WSC_POWERDOWN_RST = 1'b1;

   // register data width and bus data width
   localparam int WSC_REG_W = 8;
   localparam int WSC_BUS_W = 32;

   // postscaler count width covers the largest ratio 2^7
   localparam int WSC_POST_W = 7;

   // oscillator start-up delay in oscillator periods, and the cycle count derived from it
   localparam int WSC_OST_TOSC = 1024;
   localparam int WSC_OST_CYCLES = WSC_OST_TOSC;
   localparam int WSC_OST_W = 11;

   // sleep instruction prefetch step
   localparam int WSC_PC_STEP = 2;

   // control states, gray along run, asleep, start-up wait, resume
   typedef enum logic [1:0] {
      WSC_RUN = 2'b00,
      WSC_ASLEEP = 2'b01,
      WSC_START_WAIT = 2'b11,
      WSC_RESUME = 2'b10
   } wsc_state_e;

   // instruction strobes and global interrupt enable level from the core decoder
   typedef struct packed {
      logic clear_watchdog_instr;
      logic sleep_instr;
      logic global_irq_enable;
   } wsc_cpu_s;

endpackage : wsc_pkg

// file: core/wsc_watchdog_sleep.sv
// watchdog timer with postscaler and sleep entry and wake-up control behind an apb slave
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps

// How it works
// [R1] watchdog counts ticks of its own rc oscillator, ungated by sleep
// [R2] time-out while running pulses a device reset marked as watchdog cause
// [R3] time-out while asleep wakes the device instead of resetting
// [R4] every time-out clears the active-low time-out flag
// [R5] fuse enable on means software cannot stop the watchdog
// [R6] with fuse enable off, soft control bit 0 switches the watchdog
// [R7] soft bit resets to 0, read-write; bits 7..1 read zero
// [R8] config byte: bits 3..1 postscaler select, bit 0 fuse enable
// [R9] clear-watchdog or sleep instruction zeroes counter and postscaler count
// [R10] clearing the postscaler count leaves the selected ratio alone
// [R11] sleep entry clears watchdog, clears powerdown flag, sets time-out flag, stops oscillator
// [R12] io pins hold their pre-sleep drive and enable while asleep
// [R13] wake on master clear, watchdog wake-up, or enabled interrupt
// [R14] only clock-free peripherals may raise wake interrupts while asleep
// [R15] master clear during sleep resets; other wake sources resume execution
// [R16] powerdown flag set at power-up, cleared when sleep really executes
// [R17] sleep instruction prefetches the instruction at pc plus 2
// [R18] enabled interrupt wakes regardless of global enable; in-line when clear
// [R19] global enable set: run next instruction, then vector to interrupt
// [R20] pending enabled interrupt turns sleep into a no-operation, flags untouched
// [R21] interrupt during or after sleep: sleep completes first, then wakes at once
// [R22] crystal modes wait 1024 oscillator periods after wake; rc and ec skip
// [R23] postscaler multiplies base time-out by 2^select; overflow signals time-out
module wsc_watchdog_sleep #(
   parameter int BASE_TICKS = 256,
   parameter int BASE_W = 16,
   parameter int IRQ_N = 8,
   parameter logic [IRQ_N-1:0] WAKE_CAPABLE = {IRQ_N{1'b1}},
   parameter int IO_W = 8,
   parameter int PC_W = 21
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // non-volatile configuration and oscillator mode
   input wire logic [7:0] watchdog_config_high,
   input wire logic osc_mode_crystal,
   // watchdog rc oscillator tick
   input wire logic watchdog_rc_tick,
   // core strobes and program counter
   input wire wsc_pkg::wsc_cpu_s cpu_strobe,
   input wire logic [PC_W-1:0] pc,
   // interrupt flags and enables
   input wire logic [IRQ_N-1:0] irq_flag,
   input wire logic [IRQ_N-1:0] irq_enable,
   // master clear pin, active low
   input wire logic master_clear_pin_n,
   // io drive from the port logic
   input wire logic [IO_W-1:0] io_out_core,
   input wire logic [IO_W-1:0] io_oe_core,
   // io drive to the pads
   output logic [IO_W-1:0] io_out,
   output logic [IO_W-1:0] io_oe,
   // core and clock control
   output logic device_reset_req,
   output logic reset_by_watchdog,
   output logic cpu_run,
   output logic osc_driver_on,
   output logic wake_done,
   output logic vector_after_next,
   output logic prefetch_req,
   output logic [PC_W-1:0] prefetch_addr
);
   import wsc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // functions

   // last postscaler count before overflow for a given select
   function automatic logic [WSC_POST_W-1:0] post_last(input logic [WSC_SCALE_W-1:0] sel);
      logic [WSC_POST_W:0] ratio;
      ratio = '0;
      ratio[sel] = 1'b1;
      post_last = WSC_POST_W'(ratio - 1'b1);
   endfunction : post_last

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   wsc_state_e state;
   wsc_state_e next_state;
   logic soft_watchdog_on;
   logic timeout_flag_n;
   logic powerdown_flag_n;
   logic [BASE_W-1:0] base_cnt;
   logic [WSC_POST_W-1:0] post_cnt;
   logic [WSC_OST_W-1:0] ost_cnt;
   logic wake_vector;

   ////////////////////////////////////////////////////////////////////////////
   // configuration decode

   wire logic fuse_watchdog_on = watchdog_config_high[WSC_FUSE_ON_BIT]; // R8
   wire logic [WSC_SCALE_W-1:0] watchdog_scale_sel =
      watchdog_config_high[WSC_SCALE_MSB:WSC_SCALE_LSB]; // R8
   // fuse on overrides any software write
   wire logic watchdog_unit_on = fuse_watchdog_on | soft_watchdog_on; // R5 R6

   ////////////////////////////////////////////////////////////////////////////
   // sleep and wake decode

   wire logic is_run = (state == WSC_RUN);
   wire logic is_asleep = (state == WSC_ASLEEP);
   wire logic irq_pending = |(irq_flag & irq_enable); // R18
   // sleep is a no-operation when an enabled interrupt is already flagged
   wire logic sleep_real = is_run & cpu_strobe.sleep_instr & ~irq_pending; // R20
   wire logic clear_hit = is_run & cpu_strobe.clear_watchdog_instr;
   // clock-dependent sources are masked so they cannot wake the part
   wire logic irq_wake = is_asleep & |(irq_flag & irq_enable & WAKE_CAPABLE); // R14 R18 R21
   wire logic master_clear_hit = ~master_clear_pin_n; // R15

   ////////////////////////////////////////////////////////////////////////////
   // watchdog decode

   wire logic base_last = (base_cnt == BASE_W'(BASE_TICKS - 1));
   wire logic post_at_last = (post_cnt == post_last(watchdog_scale_sel)); // R23
   // sleep entry also clears, so a sleep and an overflow in one cycle gives no time-out
   wire logic watchdog_clear = clear_hit | sleep_real | ~watchdog_unit_on; // R9 R11
   wire logic timeout = watchdog_unit_on & watchdog_rc_tick & base_last & post_at_last
      & ~watchdog_clear; // R1 R23
   wire logic watchdog_wake = timeout & is_asleep; // R3 R13
   wire logic watchdog_reset = timeout & ~is_asleep; // R2
   wire logic any_wake = watchdog_wake | irq_wake; // R13

   ////////////////////////////////////////////////////////////////////////////
   // apb decode

   wire logic apb_setup = psel & ~penable;
   wire logic apb_access = psel & penable;
   wire logic hit_soft = (paddr == WSC_ADDR_SOFT_CONTROL);
   wire logic hit_cause = (paddr == WSC_ADDR_CAUSE_STATUS);
   wire logic hit_config = (paddr == WSC_ADDR_CONFIG_HIGH);
   wire logic hit_any = hit_soft | hit_cause | hit_config;
   wire logic soft_write = apb_access & pwrite & hit_soft;

   // read data assembly; unimplemented bits read zero
   logic [WSC_REG_W-1:0] read_byte;
   always_comb begin
      read_byte = '0;
      if (hit_soft) begin
         read_byte[WSC_SOFT_ON_BIT] = soft_watchdog_on; // R7
      end else if (hit_cause) begin
         read_byte[WSC_TIMEOUT_BIT] = timeout_flag_n;
         read_byte[WSC_POWERDOWN_BIT] = powerdown_flag_n;
      end else if (hit_config) begin
         read_byte = watchdog_config_high;
      end
   end

   // zero wait state; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = apb_access & ~hit_any;

   // read data captured in the setup cycle so it stands through the access cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         prdata <= '0;
      end else if (apb_setup) begin
         prdata <= {{(WSC_BUS_W - WSC_REG_W){1'b0}}, read_byte};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // soft control register

   // only bit 0 is kept, the rest of the write data is dropped
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         soft_watchdog_on <= WSC_SOFT_ON_RST; // R7
      end else if (soft_write) begin
         soft_watchdog_on <= pwdata[WSC_SOFT_ON_BIT]; // R6 R7
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // watchdog counter and postscaler

   // runs on rc ticks only, which keep coming while the main clock stalls the core
   always_ff @(posedge clk) begin
      if (!reset_n || watchdog_clear) begin
         base_cnt <= '0; // R9
         post_cnt <= '0; // R9 R10
      end else if (watchdog_rc_tick) begin // R1
         if (base_last) begin
            base_cnt <= '0;
            post_cnt <= post_at_last ? '0 : post_cnt + 1'b1; // R23
         end else begin
            base_cnt <= base_cnt + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status flags

   // a time-out clears, a real sleep sets; a no-operation sleep touches neither
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         timeout_flag_n <= WSC_TIMEOUT_RST;
         powerdown_flag_n <= WSC_POWERDOWN_RST; // R16
      end else begin
         if (timeout) begin
            timeout_flag_n <= 1'b0; // R4
         end else if (sleep_real) begin
            timeout_flag_n <= 1'b1; // R11 R21
         end
         if (sleep_real) begin
            powerdown_flag_n <= 1'b0; // R11 R16 R21
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sleep state machine

   always_comb begin
      next_state = state;
      case (state)
         WSC_RUN: begin
            if (sleep_real) begin
               next_state = WSC_ASLEEP; // R11
            end
         end
         WSC_ASLEEP: begin
            if (any_wake) begin
               next_state = osc_mode_crystal ? WSC_START_WAIT : WSC_RESUME; // R22
            end
         end
         WSC_START_WAIT: begin
            if (ost_cnt == WSC_OST_W'(WSC_OST_CYCLES - 1)) begin
               next_state = WSC_RESUME; // R22
            end
         end
         WSC_RESUME: begin
            next_state = WSC_RUN;
         end
         default: begin
            next_state = WSC_RUN;
         end
      endcase
   end

   // master clear drops straight back to run; the core is reset by the request
   always_ff @(posedge clk) begin
      if (!reset_n || master_clear_hit) begin
         state <= WSC_RUN; // R15
      end else begin
         state <= next_state;
      end
   end

   // start-up wait counter, held at zero outside the wait
   always_ff @(posedge clk) begin
      if (!reset_n || state != WSC_START_WAIT) begin
         ost_cnt <= '0;
      end else begin
         ost_cnt <= ost_cnt + 1'b1; // R22
      end
   end

   // remember at wake time whether an interrupt wake should vector
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wake_vector <= 1'b0;
      end else if (is_asleep && any_wake) begin
         wake_vector <= irq_wake & cpu_strobe.global_irq_enable; // R19
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // core, clock and reset outputs

   assign cpu_run = is_run;
   assign osc_driver_on = is_run | (state == WSC_START_WAIT) | (state == WSC_RESUME); // R11

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         device_reset_req <= 1'b0;
         reset_by_watchdog <= 1'b0;
         wake_done <= 1'b0;
         vector_after_next <= 1'b0;
      end else begin
         device_reset_req <= watchdog_reset | master_clear_hit; // R2 R15
         if (watchdog_reset) begin
            reset_by_watchdog <= 1'b1; // R2
         end else if (master_clear_hit) begin
            reset_by_watchdog <= 1'b0;
         end
         // resume without reset; the core runs the next instruction in line
         wake_done <= (state == WSC_RESUME) & ~master_clear_hit; // R15 R18
         vector_after_next <= (state == WSC_RESUME) & wake_vector & ~master_clear_hit; // R19
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // prefetch of the instruction after sleep

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         prefetch_req <= 1'b0;
         prefetch_addr <= '0;
      end else begin
         prefetch_req <= is_run & cpu_strobe.sleep_instr; // R17
         if (is_run && cpu_strobe.sleep_instr) begin
            prefetch_addr <= pc + PC_W'(WSC_PC_STEP); // R17
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // io hold

   // pads follow the port logic only while running; frozen otherwise
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         io_out <= '0;
         io_oe <= '0;
      end else if (is_run && !sleep_real) begin
         io_out <= io_out_core;
         io_oe <= io_oe_core;
      end else begin
         io_out <= io_out; // R12
         io_oe <= io_oe; // R12
      end
   end

endmodule : wsc_watchdog_sleep

// file: verification/tb_top.sv
// testbench: registers, watchdog periods, sleep entry and wake-up of the watchdog and sleep control
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
   $display("MISMATCH at %0t got %0h expected %0h", $time, (a), (e)); end end
module tb_top;
   import wsc_pkg::*;
   logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic osc_mode_crystal = 1'b0, master_clear_pin_n = 1'b1, watchdog_rc_tick, rst_seen = 1'b0;
   logic device_reset_req, reset_by_watchdog, cpu_run, osc_driver_on, wake_done, vector_after_next, prefetch_req;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0] watchdog_config_high = 8'h00, irq_flag = 8'h00, irq_enable = 8'h00, io_out_core = 8'h3c;
   logic [7:0] io_oe_core, io_out, io_oe;
   logic [20:0] pc, prefetch_addr;
   wsc_cpu_s cpu_strobe;
   int err_total = 0, checks = 0, n;
   assign io_oe_core = ~io_out_core;
   wsc_watchdog_sleep #(.BASE_TICKS(4), .WAKE_CAPABLE(8'h7f)) wsc_watchdog_sleep_i (.*);
   wsc_cpu_model wsc_cpu_model_i (.*);
   ////////////////////////////////////////////////////////////////////////////////
   // 100 mhz clock and a sticky record of any device reset request
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (reset_n !== 1'b1) begin
         rst_seen <= 1'b0;
      end else if (device_reset_req === 1'b1) begin
         rst_seen <= 1'b1;
      end
   end
   // apb master: request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n == 16) err_total++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask : rd_chk
   // bounded wait on run, reset request or wake completion; n ends as the edges waited
   task automatic wait_for(input int w, input int lim);
      n = 0;
      while ((w == 0 ? cpu_run : w == 1 ? device_reset_req : wake_done) !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
      if (n == lim) err_total++;
   endtask : wait_for
   task automatic do_reset(input int c);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (c) @(posedge clk);
      reset_n <= 1'b1;
   endtask : do_reset
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      watchdog_config_high <= 8'h04;
      rd_chk(WSC_ADDR_SOFT_CONTROL, 32'h0);
      apb(1'b1, WSC_ADDR_SOFT_CONTROL, 32'hffff_ffff);
      rd_chk(WSC_ADDR_SOFT_CONTROL, 32'h1);
      rd_chk(WSC_ADDR_CAUSE_STATUS, 32'h0c);
      apb(1'b1, WSC_ADDR_CAUSE_STATUS, 32'h0);
      rd_chk(WSC_ADDR_CAUSE_STATUS, 32'h0c);
      rd_chk(WSC_ADDR_CONFIG_HIGH, 32'h04);
      apb(1'b0, 12'h0f0, 32'h0);
      `CHK({err, rd}, 33'h1_0000_0000)
      apb(1'b1, WSC_ADDR_SOFT_CONTROL, 32'h0);
      $display("test regs finished");
   endtask : t_regs
   // period grows as a power of two of the select field; soft bit switches it
   task automatic t_period();
      for (int s = 0; s < 3; s++) begin
         watchdog_config_high <= {4'h0, 3'(s), 1'b0};
         do_reset(2);
         repeat (40) @(posedge clk);
         `CHK(rst_seen, 1'b0)
         apb(1'b1, WSC_ADDR_SOFT_CONTROL, 32'h1);
         wait_for(1, 200);
         `CHK(n >= (8 << s) - 2 && n <= (8 << s) + 3, 1'b1)
         `CHK(reset_by_watchdog, 1'b1)
         rd_chk(WSC_ADDR_CAUSE_STATUS, 32'h04);
      end
      $display("test period finished");
   endtask : t_period
   // fuse on with the soft bit cleared; clears hold it off, ratio survives them
   task automatic t_clear();
      watchdog_config_high <= 8'h03;
      do_reset(2);
      apb(1'b1, WSC_ADDR_SOFT_CONTROL, 32'h0);
      repeat (6) begin
         wsc_cpu_model_i.clear_op();
         repeat (3) @(posedge clk);
      end
      `CHK(rst_seen, 1'b0)
      wait_for(1, 40);
      `CHK(n >= 11 && n <= 16, 1'b1)
      $display("test clear finished");
   endtask : t_clear
   task automatic t_sleep_wd();
      do_reset(2);
      wsc_cpu_model_i.sleep_op(21'h1ffffe);
      io_out_core <= 8'hc3;
      @(negedge clk);
      `CHK({cpu_run, osc_driver_on, prefetch_req, prefetch_addr}, {3'b001, 21'h0})
      rd_chk(WSC_ADDR_CAUSE_STATUS, 32'h08);
      `CHK({io_oe, io_out}, 16'hc33c)
      wait_for(0, 60);
      `CHK(rst_seen, 1'b0)
      rd_chk(WSC_ADDR_CAUSE_STATUS, 32'h00);
      $display("test sleep watchdog finished");
   endtask : t_sleep_wd
   // crystal with global enable, then rc without; bit 7 cannot wake, bit 1 is not enabled
   task automatic t_irq();
      for (int c = 0; c < 2; c++) begin
         watchdog_config_high <= 8'h00;
         osc_mode_crystal <= c == 0;
         wsc_cpu_model_i.set_irq_enable(c == 0);
         irq_enable <= 8'h84;
         do_reset(2);
         wsc_cpu_model_i.sleep_op(21'h000100);
         irq_flag <= 8'h82;
         repeat (20) @(posedge clk);
         `CHK(cpu_run, 1'b0)
         irq_flag <= 8'h86;
         wait_for(2, 1100);
         `CHK(vector_after_next, c == 0)
         `CHK(c == 0 ? n >= 1024 : n <= 5, 1'b1)
         irq_flag <= 8'h00;
         rd_chk(WSC_ADDR_CAUSE_STATUS, 32'h08);
      end
      $display("test interrupt wake finished");
   endtask : t_irq
   task automatic t_nop();
      do_reset(2);
      irq_enable <= 8'h04;
      irq_flag <= 8'h04;
      wsc_cpu_model_i.sleep_op(21'h000200);
      @(negedge clk);
      `CHK({cpu_run, prefetch_req}, 2'b11)
      rd_chk(WSC_ADDR_CAUSE_STATUS, 32'h0c);
      irq_flag <= 8'h00;
      $display("test no-op sleep finished");
   endtask : t_nop
   task automatic t_master_clear();
      do_reset(2);
      wsc_cpu_model_i.sleep_op(21'h000300);
      repeat (3) @(posedge clk);
      master_clear_pin_n <= 1'b0;
      @(posedge clk);
      master_clear_pin_n <= 1'b1;
      @(negedge clk);
      `CHK({device_reset_req, cpu_run, reset_by_watchdog}, 3'b110)
      $display("test master clear finished");
   endtask : t_master_clear
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   // the whole run is near 1500 cycles; the limit leaves wide margin
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      give_verdict();
   end
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      t_regs();
      t_period();
      t_clear();
      t_sleep_wd();
      t_irq();
      t_nop();
      t_master_clear();
      give_verdict();
   end
endmodule : tb_top

// file: verification/wsc_cpu_model.sv
// partner model: core instruction strobes, program counter and the watchdog rc oscillator
`timescale 1ns/1ps
module wsc_cpu_model
   import wsc_pkg::*;
#(
   parameter int PC_W = 21
) (
   // clock
   input wire logic clk,
   // to the block
   output wsc_pkg::wsc_cpu_s cpu_strobe,
   output logic [PC_W-1:0] pc,
   output logic watchdog_rc_tick
);
   logic clr = 1'b0;
   logic slp = 1'b0;
   logic global_irq_enable = 1'b0;
   initial pc = '0;
   assign cpu_strobe = {clr, slp, global_irq_enable};
   ////////////////////////////////////////////////////////////////////////////////
   // rc tick runs free of sleep, one pulse every other cycle
   // one process owns the tick; it starts unknown only before the first edge, inside reset
   always @(posedge clk) watchdog_rc_tick <= (watchdog_rc_tick !== 1'b1);
   // global interrupt enable level, changed only between transfers
   task automatic set_irq_enable(input logic on);
      global_irq_enable <= on;
   endtask : set_irq_enable
   // sleep instruction strobe for one cycle at the given address
   task automatic sleep_op(input logic [PC_W-1:0] at);
      @(posedge clk);
      slp <= 1'b1;
      pc <= at;
      @(posedge clk);
      slp <= 1'b0;
   endtask : sleep_op
   // clear-watchdog strobe for one cycle
   task automatic clear_op();
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
   endtask : clear_op
endmodule : wsc_cpu_model

// file: verification/wsc_watchdog_sleep_props.sv
// checker: timing relations at the ports of the watchdog and sleep control
`timescale 1ns/1ps
module wsc_watchdog_sleep_props
   import wsc_pkg::*;
#(
   parameter int IRQ_N = 8,
   parameter int IO_W = 8,
   parameter int PC_W = 21
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // core side inputs
   input wire wsc_pkg::wsc_cpu_s cpu_strobe,
   input wire logic [PC_W-1:0] pc,
   input wire logic [IRQ_N-1:0] irq_flag,
   input wire logic [IRQ_N-1:0] irq_enable,
   input wire logic master_clear_pin_n,
   input wire logic osc_mode_crystal,
   // outputs under watch
   input wire logic [IO_W-1:0] io_out,
   input wire logic [IO_W-1:0] io_oe,
   input wire logic device_reset_req,
   input wire logic reset_by_watchdog,
   input wire logic cpu_run,
   input wire logic osc_driver_on,
   input wire logic wake_done,
   input wire logic vector_after_next,
   input wire logic prefetch_req,
   input wire logic [PC_W-1:0] prefetch_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////////////
   // decode of a sleep taken in run and of a pending enabled interrupt
   wire go_sleep = cpu_run && cpu_strobe.sleep_instr && master_clear_pin_n;
   wire pending = |(irq_flag & irq_enable);
   // cycles awake but not yet running; a plain counter since the wait is far beyond a repetition
   logic [11:0] wait_cnt;
   wire [11:0] next_wait_cnt = (!cpu_run && osc_driver_on) ? wait_cnt + 12'h001 : 12'h000;
   always_ff @(posedge clk) begin
      wait_cnt <= reset_n ? next_wait_cnt : 12'h000;
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_sleep_enter: assert property (go_sleep && !pending |=> !cpu_run && !osc_driver_on)
      else $error("sleep did not stop core and oscillator");
   a_nop_sleep: assert property (go_sleep && pending |=> cpu_run && prefetch_req)
      else $error("pending interrupt sleep did not act as no-op");
   a_prefetch_pc: assert property (go_sleep |=> prefetch_req && prefetch_addr == PC_W'($past(pc) + 2))
      else $error("prefetch address wrong after sleep");
   a_io_hold: assert property (!cpu_run && master_clear_pin_n |=> $stable(io_out) && $stable(io_oe))
      else $error("io drive changed while not running");
   a_wd_cause: assert property ($rose(device_reset_req) && $past(master_clear_pin_n) |-> reset_by_watchdog)
      else $error("reset without watchdog cause");
   a_master_clear_rst: assert property (!master_clear_pin_n |=> device_reset_req && cpu_run && !reset_by_watchdog)
      else $error("master clear did not reset");
   a_asleep_no_rst: assert property (!osc_driver_on && master_clear_pin_n |=> !device_reset_req)
      else $error("reset raised while asleep");
   a_rc_no_wait: assert property (wake_done && !osc_mode_crystal |-> wait_cnt == 12'h001)
      else $error("start-up wait seen in rc mode");
   a_xtal_wait: assert property (wake_done && osc_mode_crystal |-> wait_cnt >= 12'h400 && wait_cnt <= 12'h402)
      else $error("crystal start-up wait wrong");
   a_vector_pair: assert property (vector_after_next |-> wake_done)
      else $error("vector request outside a wake");
endmodule : wsc_watchdog_sleep_props

bind wsc_watchdog_sleep wsc_watchdog_sleep_props #(.IRQ_N(IRQ_N), .IO_W(IO_W), .PC_W(PC_W))
   wsc_watchdog_sleep_props_i (.*);
